// ### rtl/cmc_defines.vh
`ifndef CMC_DEFINES_VH
`define CMC_DEFINES_VH

// avalon word addresses
`define CMC_ADDR_W 3
`define CMC_OFS_CONTROL_1 3'h0
`define CMC_OFS_CONFIG_2 3'h1
`define CMC_OFS_BAUD 3'h2
`define CMC_OFS_FILTER 3'h3
`define CMC_OFS_STATUS 3'h4
`define CMC_OFS_ERRCNT 3'h5

// can_control_1 fields
`define CMC_REQ_HI 10
`define CMC_REQ_LO 8
`define CMC_CUR_HI 7
`define CMC_CUR_LO 5
// can_config_2 fields
`define CMC_WAKFILT_BIT 14
// status fields
`define CMC_ST_WAKE 0
`define CMC_ST_ABORT 1
`define CMC_ST_TX_REQUEST_FLAG 2
`define CMC_ST_TXBUSY 3
`define CMC_ST_IDLE 4
`define CMC_ST_ENTRYWAIT 5

// mode codes
`define CMC_MODE_NORMAL 3'h0
`define CMC_MODE_DISABLE 3'h1
`define CMC_MODE_LOOPBACK 3'h2
`define CMC_MODE_LISTEN 3'h3
`define CMC_MODE_INIT 3'h4
`define CMC_MODE_LISTEN_ALL 3'h7

// reset values
`define CMC_RST_MODE 3'h4
`define CMC_RST_CFG 16'h0000

// timing
`define CMC_IDLE_BITS 11
`define CMC_BIT_CYCLES 40
`define CMC_CLK_MHZ 40
`define CMC_WAKE_FILT_NS 250
`define CMC_WAKE_FILT_CYC ((`CMC_WAKE_FILT_NS * `CMC_CLK_MHZ + 999) / 1000)

`endif

// ### rtl/cmc_sync.v
`timescale 1ns/100ps
module cmc_sync (
  input wire clk_in, // module clock
  input wire rstn_in, // synchronised reset, active low
  input wire async_in, // level from outside the clock domain
  output reg level_out // accepted level, recessive after reset
);
  reg s1;
  reg s2;
  reg s3;

  // a change counts only once the second and third stages agree
  always @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      s1 <= 1'b1;
      s2 <= 1'b1;
      s3 <= 1'b1;
      level_out <= 1'b1;
    end else begin
      s1 <= async_in;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3)
        level_out <= s3;
    end
  end
endmodule // cmc_sync

// ### rtl/cmc_idle_det.v
`timescale 1ns/100ps
`include "cmc_defines.vh"
module cmc_idle_det #(
  parameter BIT_CYCLES = `CMC_BIT_CYCLES,
  parameter IDLE_BITS = `CMC_IDLE_BITS
) (
  input wire clk_in, // module clock
  input wire rstn_in, // synchronised reset, active low
  input wire rx_in, // synchronised bus level, 1 = recessive
  input wire restart_in, // start counting afresh
  output reg idle_out // at least IDLE_BITS recessive bits seen
);
  reg [15:0] cyc;
  reg [4:0] bits;

  // any dominant level or a restart throws away the run so far
  always @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cyc <= 16'h0000;
      bits <= 5'h00;
      idle_out <= 1'b0;
    end else if (restart_in || !rx_in) begin
      cyc <= 16'h0000;
      bits <= 5'h00;
      idle_out <= 1'b0;
    end else if (!idle_out) begin
      if (cyc == BIT_CYCLES[15:0] - 16'h0001) begin
        cyc <= 16'h0000;
        bits <= bits + 5'h01;
        if (bits == IDLE_BITS[4:0] - 5'h01)
          idle_out <= 1'b1;
      end else begin
        cyc <= cyc + 16'h0001;
      end
    end
  end
endmodule // cmc_idle_det

// ### rtl/cmc_mode_ctrl.v
// Local design decisions: the Avalon-MM slave port and the register offsets.
`timescale 1ns/100ps
`include "cmc_defines.vh"
// Contract
// - software writes requested mode at bits 10:8
// - granted mode readable at bits 7:5
// - mode change waits for 11 recessive bits, except when leaving disable
// - initialization mode: no transmit, no receive
// - entering initialization clears counters, keeps flags
// - configuration writes only in initialization mode
// - initialization refused while transmission in progress
// - disable: silent, flags and counters kept
// - disable mode sets wake flag on activity
// - disable request from active waits idle bus
// - disable mode reads back as 001
// - disable mode releases both bus pins
// - wake filter enable low-passes the wake-detect input while asleep or disabled
// - first transmission after mode entry waits idle
// - disable during that wait aborts transmission
// - code 000 gives normal operation
// - code 111 ignores errors, accepts everything
// - listen-only passive, no ack, no counting
// - loopback joins transmit to receive, pins released
module cmc_mode_ctrl #(
  parameter BIT_CYCLES = `CMC_BIT_CYCLES,
  parameter FILT_CYCLES = `CMC_WAKE_FILT_CYC
) (
  input wire clk_in, // 40 MHz module clock
  input wire rstn_in, // asynchronous reset, active low
  input wire [`CMC_ADDR_W-1:0] avs_address, // word address
  input wire avs_read, // read request
  input wire avs_write, // write request
  input wire [31:0] avs_writedata, // write data
  output reg [31:0] avs_readdata, // read data
  output wire avs_waitrequest, // high until request is answered
  input wire bus_receive_pin_in, // can receive pin
  output reg bus_transmit_pin_out, // can transmit pin level
  output wire bus_transmit_pin_oe_out, // transmit pin driven
  output wire pins_owned_out, // pins held by can logic, else gpio
  input wire sleep_in, // processor sleep
  input wire eng_tx_bit_in, // engine transmit bit
  input wire eng_tx_active_in, // engine sending a frame
  input wire eng_tx_done_in, // pulse: frame sent
  input wire eng_tx_err_in, // pulse: transmit error seen
  input wire eng_rx_err_in, // pulse: receive error seen
  output reg eng_rx_bit_out, // receive bit to engine
  output wire eng_tx_enable_out, // engine may transmit
  output wire eng_rx_enable_out, // engine may receive
  output wire eng_ack_enable_out, // engine may send ack and error flags
  output wire eng_ignore_err_out, // keep data assembled up to an error
  output wire eng_tx_go_out // start the pending frame
);
  reg rst_s1;
  reg rstn;
  reg [2:0] req_mode;
  reg [2:0] cur_mode;
  reg [15:0] cfg2;
  reg [15:0] baud;
  reg [15:0] filt;
  reg wake_flag;
  reg tx_aborted_flag;
  reg tx_request_flag;
  reg entry_wait;
  reg [7:0] tx_err;
  reg [7:0] rx_err;
  reg done;
  reg [15:0] fcnt;
  reg rx_filt;
  reg wake_prev;
  reg restart;
  wire rx_sync;
  wire bus_idle;
  wire acc;
  wire wr_ok;
  wire rd_now;
  wire grant;
  wire locked_ok;
  wire abort_now;
  wire wake_rx;
  wire wake_edge;
  wire entered;
  reg [15:0] next_rdata;

  function is_valid;
    input [2:0] m;
    begin
      is_valid = (m == `CMC_MODE_NORMAL) || (m == `CMC_MODE_DISABLE) ||
        (m == `CMC_MODE_LOOPBACK) || (m == `CMC_MODE_LISTEN) ||
        (m == `CMC_MODE_INIT) || (m == `CMC_MODE_LISTEN_ALL);
    end
  endfunction

  function tx_capable;
    input [2:0] m;
    begin
      tx_capable = (m == `CMC_MODE_NORMAL) || (m == `CMC_MODE_LOOPBACK);
    end
  endfunction

  // reset release through two flops
  always @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rst_s1 <= 1'b0;
      rstn <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rstn <= rst_s1;
    end
  end

  cmc_sync u_rx_sync (
    .clk_in(clk_in),
    .rstn_in(rstn),
    .async_in(bus_receive_pin_in),
    .level_out(rx_sync)
  );

  cmc_idle_det #(
    .BIT_CYCLES(BIT_CYCLES),
    .IDLE_BITS(`CMC_IDLE_BITS)
  ) u_idle (
    .clk_in(clk_in),
    .rstn_in(rstn),
    .rx_in(rx_sync),
    .restart_in(restart),
    .idle_out(bus_idle)
  );

  // avalon: one wait cycle, answer on the second edge
  assign acc = (avs_read || avs_write) && done;
  assign avs_waitrequest = (avs_read || avs_write) && !done;
  assign wr_ok = avs_write && done;
  assign rd_now = avs_read && !done;

  // leaving disable needs no idle wait; init also waits for frame end
  assign grant = (req_mode != cur_mode) && is_valid(req_mode) &&
    (cur_mode == `CMC_MODE_DISABLE || bus_idle) &&
    !(req_mode == `CMC_MODE_INIT && eng_tx_active_in);
  assign entered = grant;
  assign locked_ok = (cur_mode == `CMC_MODE_INIT);
  assign abort_now = entry_wait && tx_request_flag &&
    (req_mode == `CMC_MODE_DISABLE);

  // wake path filter only while asleep or disabled
  assign wake_rx = (cfg2[`CMC_WAKFILT_BIT] &&
    (sleep_in || cur_mode == `CMC_MODE_DISABLE)) ? rx_filt : rx_sync;
  assign wake_edge = wake_prev && !wake_rx;

  always @(posedge clk_in or negedge rstn) begin
    if (!rstn) begin
      done <= 1'b0;
    end else begin
      done <= (avs_read || avs_write) && !done;
    end
  end

  // mode state and protected configuration
  always @(posedge clk_in or negedge rstn) begin
    if (!rstn) begin
      req_mode <= `CMC_RST_MODE;
      cur_mode <= `CMC_RST_MODE;
      cfg2 <= `CMC_RST_CFG;
      baud <= `CMC_RST_CFG;
      filt <= `CMC_RST_CFG;
      restart <= 1'b0;
    end else begin
      restart <= grant;
      if (grant)
        cur_mode <= req_mode;
      if (wr_ok) begin
        if (avs_address == `CMC_OFS_CONTROL_1) begin
          req_mode <= avs_writedata[`CMC_REQ_HI:`CMC_REQ_LO];
        end else if (avs_address == `CMC_OFS_CONFIG_2) begin
          if (locked_ok)
            cfg2 <= avs_writedata[15:0];
        end else if (avs_address == `CMC_OFS_BAUD) begin
          if (locked_ok)
            baud <= avs_writedata[15:0];
        end else if (avs_address == `CMC_OFS_FILTER) begin
          if (locked_ok)
            filt <= avs_writedata[15:0];
        end
      end
    end
  end

  // flags: a hardware set or clear wins over a software write in the same edge
  always @(posedge clk_in or negedge rstn) begin
    if (!rstn) begin
      wake_flag <= 1'b0;
      tx_aborted_flag <= 1'b0;
      tx_request_flag <= 1'b0;
      entry_wait <= 1'b0;
    end else begin
      if (wake_edge && cur_mode == `CMC_MODE_DISABLE)
        wake_flag <= 1'b1;
      else if (wr_ok && avs_address == `CMC_OFS_STATUS &&
               avs_writedata[`CMC_ST_WAKE])
        wake_flag <= 1'b0;
      if (abort_now)
        tx_aborted_flag <= 1'b1;
      else if (wr_ok && avs_address == `CMC_OFS_STATUS &&
               avs_writedata[`CMC_ST_ABORT])
        tx_aborted_flag <= 1'b0;
      if (abort_now || eng_tx_done_in)
        tx_request_flag <= 1'b0;
      else if (wr_ok && avs_address == `CMC_OFS_STATUS &&
               avs_writedata[`CMC_ST_TX_REQUEST_FLAG])
        tx_request_flag <= 1'b1;
      if (entered)
        entry_wait <= tx_capable(req_mode);
      else if (bus_idle && !restart)
        entry_wait <= 1'b0;
    end
  end

  // error counters
  always @(posedge clk_in or negedge rstn) begin
    if (!rstn) begin
      tx_err <= 8'h00;
      rx_err <= 8'h00;
    end else if (entered && req_mode == `CMC_MODE_INIT) begin
      tx_err <= 8'h00;
      rx_err <= 8'h00;
    end else if (tx_capable(cur_mode)) begin
      // disable, listen-only and listen-all leave them untouched
      if (eng_tx_err_in && tx_err != 8'hFF)
        tx_err <= tx_err + 8'h01;
      if (eng_rx_err_in && rx_err != 8'hFF)
        rx_err <= rx_err + 8'h01;
    end
  end

  // wake low-pass: level must hold FILT_CYCLES before it is believed
  always @(posedge clk_in or negedge rstn) begin
    if (!rstn) begin
      fcnt <= 16'h0000;
      rx_filt <= 1'b1;
      wake_prev <= 1'b1;
    end else begin
      wake_prev <= wake_rx;
      if (rx_sync == rx_filt) begin
        fcnt <= 16'h0000;
      end else if (fcnt == FILT_CYCLES[15:0] - 16'h0001) begin
        fcnt <= 16'h0000;
        rx_filt <= rx_sync;
      end else begin
        fcnt <= fcnt + 16'h0001;
      end
    end
  end

  // bus pins and engine data
  always @(posedge clk_in or negedge rstn) begin
    if (!rstn) begin
      bus_transmit_pin_out <= 1'b1;
      eng_rx_bit_out <= 1'b1;
    end else begin
      bus_transmit_pin_out <= (cur_mode == `CMC_MODE_NORMAL) ?
        eng_tx_bit_in : 1'b1;
      eng_rx_bit_out <= (cur_mode == `CMC_MODE_LOOPBACK) ?
        eng_tx_bit_in : rx_sync;
    end
  end

  // pins go back to gpio in disable and loopback
  assign pins_owned_out = (cur_mode != `CMC_MODE_DISABLE) &&
    (cur_mode != `CMC_MODE_LOOPBACK);
  assign bus_transmit_pin_oe_out = (cur_mode == `CMC_MODE_NORMAL) ||
    (cur_mode == `CMC_MODE_INIT) ||
    (cur_mode == `CMC_MODE_LISTEN_ALL);
  assign eng_tx_enable_out = tx_capable(cur_mode);
  assign eng_rx_enable_out = (cur_mode != `CMC_MODE_INIT) &&
    (cur_mode != `CMC_MODE_DISABLE);
  assign eng_ack_enable_out = tx_capable(cur_mode);
  assign eng_ignore_err_out = (cur_mode == `CMC_MODE_LISTEN_ALL);
  assign eng_tx_go_out = tx_request_flag && tx_capable(cur_mode) &&
    !entry_wait && !grant;

  // read mux, registered so data stand when waitrequest drops
  always @* begin
    next_rdata = 16'h0000;
    if (avs_address == `CMC_OFS_CONTROL_1) begin
      next_rdata[`CMC_REQ_HI:`CMC_REQ_LO] = req_mode;
      next_rdata[`CMC_CUR_HI:`CMC_CUR_LO] = cur_mode;
    end else if (avs_address == `CMC_OFS_CONFIG_2) begin
      next_rdata = cfg2;
    end else if (avs_address == `CMC_OFS_BAUD) begin
      next_rdata = baud;
    end else if (avs_address == `CMC_OFS_FILTER) begin
      next_rdata = filt;
    end else if (avs_address == `CMC_OFS_STATUS) begin
      next_rdata[`CMC_ST_WAKE] = wake_flag;
      next_rdata[`CMC_ST_ABORT] = tx_aborted_flag;
      next_rdata[`CMC_ST_TX_REQUEST_FLAG] = tx_request_flag;
      next_rdata[`CMC_ST_TXBUSY] = eng_tx_active_in;
      next_rdata[`CMC_ST_IDLE] = bus_idle;
      next_rdata[`CMC_ST_ENTRYWAIT] = entry_wait;
    end else if (avs_address == `CMC_OFS_ERRCNT) begin
      next_rdata = {rx_err, tx_err};
    end
  end

  always @(posedge clk_in or negedge rstn) begin
    if (!rstn) begin
      avs_readdata <= 32'h00000000;
    end else if (rd_now) begin
      avs_readdata <= {16'h0000, next_rdata};
    end
  end

  // acc kept for clarity of the accepted edge; reads have no side effect
  wire unused_acc = acc;
endmodule // cmc_mode_ctrl

// ### tb/cmc_mode_ctrl_properties.sv
`timescale 1ns/100ps
module cmc_mode_ctrl_properties (
  input wire clk_in, // clock
  input wire rstn_in, // reset, active low
  input wire avs_read, // read request
  input wire avs_write, // write request
  input wire avs_waitrequest, // wait
  input wire bus_transmit_pin_out, // tx pin
  input wire bus_transmit_pin_oe_out, // tx pin driven
  input wire pins_owned_out, // pins held
  input wire eng_tx_bit_in, // engine tx bit
  input wire eng_rx_bit_out, // engine rx bit
  input wire eng_tx_enable_out, // tx allowed
  input wire eng_rx_enable_out, // rx allowed
  input wire eng_ack_enable_out, // ack allowed
  input wire eng_ignore_err_out, // keep errored data
  input wire eng_tx_go_out // start frame
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  a_one_wait: assert property (
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer not after one wait cycle");
  a_init_silent: assert property (
    bus_transmit_pin_oe_out && !eng_rx_enable_out
    |-> !eng_tx_enable_out && !eng_tx_go_out)
    else $error("traffic allowed in initialization");
  a_disable_silent: assert property (
    !pins_owned_out && !eng_tx_enable_out |-> !eng_rx_enable_out)
    else $error("receive allowed while disabled");
  a_pins_released: assert property (
    !pins_owned_out |-> !bus_transmit_pin_oe_out)
    else $error("tx pin driven while released");
  a_tx_recessive: assert property (
    !eng_tx_enable_out && $past(!eng_tx_enable_out)
    |-> bus_transmit_pin_out)
    else $error("tx pin dominant without transmit");
  a_go_gated: assert property (
    eng_tx_go_out |-> eng_tx_enable_out)
    else $error("frame started while transmit barred");
  a_ack_tracks: assert property (
    eng_ack_enable_out == eng_tx_enable_out)
    else $error("ack enable differs from transmit enable");
  a_ignore_mode: assert property (
    eng_ignore_err_out |-> eng_rx_enable_out && !eng_ack_enable_out)
    else $error("ignore errors outside listen all");
  a_loop_echo: assert property (
    !pins_owned_out && eng_tx_enable_out
    && $past(!pins_owned_out && eng_tx_enable_out)
    |-> eng_rx_bit_out == $past(eng_tx_bit_in))
    else $error("loopback bit not echoed");
  c_loop: cover property (!pins_owned_out && eng_tx_enable_out);
  c_off: cover property (!pins_owned_out && !eng_tx_enable_out);
  c_all: cover property (eng_ignore_err_out);
  c_go: cover property (eng_tx_go_out);
endmodule // cmc_mode_ctrl_properties

// ### tb/cmc_can_node.sv
`timescale 1ns/100ps
module cmc_can_node (
  input wire clk_in, // bit timebase
  input wire busy_in, // keep traffic on the bus
  output wire rx_out // bus level, 1 = recessive
);
  reg [7:0] cnt = 8'h00;
  always @(posedge clk_in) cnt <= cnt + 8'h01;
  // four-bit dominant runs outlast the wake filter, never 11 bits idle
  assign rx_out = !busy_in || cnt[4];
endmodule // cmc_can_node

// ### tb/cmc_mode_ctrl_tb.sv
`timescale 1ns/100ps
module cmc_mode_ctrl_tb;
  reg clk_in = 1'h0;
  reg rstn_in = 1'h0;
  reg [2:0] avs_address = 3'h0;
  reg avs_read = 1'h0;
  reg avs_write = 1'h0;
  reg [31:0] avs_writedata = 32'h0;
  reg tx_bit = 1'h1, tx_act = 1'h0, tx_done = 1'h0;
  reg tx_err = 1'h0, rx_err = 1'h0, busy = 1'h0;
  reg [31:0] rd_data;
  wire [31:0] avs_readdata;
  wire avs_waitrequest, rx_pin, tx_pin, tx_oe, owned, rx_bit;
  wire tx_en, rx_en, ack_en, ign, go;
  integer fail_count = 0;
  integer compares = 0;

  initial forever #12.5 clk_in = ~clk_in;

  cmc_mode_ctrl #(.BIT_CYCLES(4)) dut (
    .clk_in(clk_in), .rstn_in(rstn_in), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .bus_receive_pin_in(rx_pin),
    .bus_transmit_pin_out(tx_pin), .bus_transmit_pin_oe_out(tx_oe),
    .pins_owned_out(owned), .sleep_in(1'h0), .eng_tx_bit_in(tx_bit),
    .eng_tx_active_in(tx_act), .eng_tx_done_in(tx_done),
    .eng_tx_err_in(tx_err), .eng_rx_err_in(rx_err),
    .eng_rx_bit_out(rx_bit), .eng_tx_enable_out(tx_en),
    .eng_rx_enable_out(rx_en), .eng_ack_enable_out(ack_en),
    .eng_ignore_err_out(ign), .eng_tx_go_out(go));
  cmc_can_node node (.clk_in(clk_in), .busy_in(busy), .rx_out(rx_pin));

  function automatic logic [31:0] pins();
    return {26'h0, tx_oe, owned, tx_en, rx_en, ack_en, ign};
  endfunction

  task chk(input string nm, input [31:0] e, input [31:0] g);
    compares = compares + 1;
    if (g !== e) begin
      fail_count = fail_count + 1;
      $display("unexpected %0s: expected %h seen %h", nm, e, g);
    end
  endtask

  // request held until the edge that sees waitrequest low; data taken there
  task bus(input rw, input [2:0] a, input [31:0] d);
    begin
      @(posedge clk_in);
      avs_address <= a;
      avs_writedata <= d;
      avs_read <= !rw;
      avs_write <= rw;
      @(posedge clk_in);
      while (avs_waitrequest)
        @(posedge clk_in);
      rd_data = avs_readdata;
      avs_read <= 1'h0;
      avs_write <= 1'h0;
    end
  endtask

  task wait_mode(input [2:0] m);
    integer i;
    begin
      i = 0;
      do begin
        bus(1'h0, 3'h0, 32'h0);
        i = i + 1;
      end while (rd_data[7:5] !== m && i < 40);
      chk("current mode", 32'(m), 32'(rd_data[7:5]));
    end
  endtask

  task t_reset;
    bus(1'h0, 3'h0, 32'h0);
    chk("control_1", 32'h480, rd_data);
    chk("pins", 32'h30, pins());
    bus(1'h1, 3'h1, 32'h4000);
    bus(1'h0, 3'h1, 32'h0);
    chk("config_2", 32'h4000, rd_data);
    $display("test reset done");
  endtask

  task t_normal_abort;
    busy <= 1'h1;
    bus(1'h1, 3'h0, 32'h0);
    repeat (80) @(posedge clk_in);
    bus(1'h0, 3'h0, 32'h0);
    chk("control_1", 32'h80, rd_data);
    busy <= 1'h0;
    wait_mode(3'h0);
    busy <= 1'h1;
    chk("pins", 32'h3E, pins());
    bus(1'h1, 3'h1, 32'h0);
    bus(1'h0, 3'h1, 32'h0);
    chk("config_2", 32'h4000, rd_data);
    bus(1'h1, 3'h4, 32'h4);
    @(negedge clk_in);
    chk("go", 32'h0, 32'(go));
    bus(1'h1, 3'h0, 32'h100);
    bus(1'h0, 3'h4, 32'h0);
    chk("status", 32'h2, rd_data & 32'h7);
    bus(1'h0, 3'h0, 32'h0);
    chk("control_1", 32'h100, rd_data);
    busy <= 1'h0;
    wait_mode(3'h1);
    chk("pins", 32'h0, pins());
    $display("test normal and abort done");
  endtask

  task t_wake;
    bus(1'h1, 3'h4, 32'h3);
    busy <= 1'h1;
    repeat (40) @(posedge clk_in);
    busy <= 1'h0;
    bus(1'h0, 3'h4, 32'h0);
    chk("wake", 32'h1, rd_data & 32'h3);
    bus(1'h1, 3'h4, 32'h1);
    bus(1'h0, 3'h4, 32'h0);
    chk("wake clear", 32'h0, rd_data & 32'h3);
    $display("test wake done");
  endtask

  task t_tx_init;
    integer i;
    begin
      bus(1'h1, 3'h0, 32'h0);
      wait_mode(3'h0);
      bus(1'h1, 3'h4, 32'h4);
      i = 0;
      do begin
        @(negedge clk_in);
        i = i + 1;
      end while (go !== 1'h1 && i < 100);
      chk("go", 32'h1, 32'(go));
      tx_bit <= 1'h0;
      repeat (2) @(posedge clk_in);
      @(negedge clk_in);
      chk("tx pin", 32'h0, 32'(tx_pin));
      tx_bit <= 1'h1;
      @(posedge clk_in);
      tx_act <= 1'h1;
      tx_err <= 1'h1;
      rx_err <= 1'h1;
      @(posedge clk_in);
      tx_err <= 1'h0;
      rx_err <= 1'h0;
      bus(1'h0, 3'h5, 32'h0);
      chk("errcnt", 32'h101, rd_data);
      bus(1'h1, 3'h0, 32'h400);
      repeat (80) @(posedge clk_in);
      bus(1'h0, 3'h0, 32'h0);
      chk("control_1", 32'h400, rd_data);
      tx_act <= 1'h0;
      tx_done <= 1'h1;
      @(posedge clk_in);
      tx_done <= 1'h0;
      wait_mode(3'h4);
      bus(1'h0, 3'h5, 32'h0);
      chk("errcnt", 32'h0, rd_data);
      $display("test transmit and init done");
    end
  endtask

  task t_modes;
    localparam [8:0] CODES = {3'h7, 3'h3, 3'h2};
    localparam [17:0] EXP = {6'h35, 6'h14, 6'h0E};
    integer k;
    begin
      for (k = 0; k < 3; k = k + 1) begin
        bus(1'h1, 3'h0, {21'h0, CODES[3*k +: 3], 8'h0});
        wait_mode(CODES[3*k +: 3]);
        chk("pins", 32'(EXP[6*k +: 6]), pins());
        if (k == 0) begin
          tx_bit <= 1'h0;
          repeat (3) @(posedge clk_in);
          chk("echo", 32'h0, 32'(rx_bit));
          tx_bit <= 1'h1;
        end
      end
      bus(1'h1, 3'h0, 32'h500);
      repeat (80) @(posedge clk_in);
      bus(1'h0, 3'h0, 32'h0);
      chk("control_1", 32'h5E0, rd_data);
      $display("test modes done");
    end
  endtask

  task finish_test;
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial begin
    repeat (5) @(posedge clk_in);
    rstn_in <= 1'h1;
    repeat (3) @(posedge clk_in);
    t_reset;
    t_normal_abort;
    t_wake;
    t_tx_init;
    t_modes;
    finish_test;
  end

  // the tests need several hundred cycles
  initial begin
    #500000;
    fail_count = fail_count + 1;
    finish_test;
  end
endmodule // cmc_mode_ctrl_tb

bind cmc_mode_ctrl cmc_mode_ctrl_properties chk (
  .clk_in(clk_in), .rstn_in(rstn_in), .avs_read(avs_read),
  .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
  .bus_transmit_pin_out(bus_transmit_pin_out),
  .bus_transmit_pin_oe_out(bus_transmit_pin_oe_out),
  .pins_owned_out(pins_owned_out), .eng_tx_bit_in(eng_tx_bit_in),
  .eng_rx_bit_out(eng_rx_bit_out), .eng_tx_enable_out(eng_tx_enable_out),
  .eng_rx_enable_out(eng_rx_enable_out),
  .eng_ack_enable_out(eng_ack_enable_out),
  .eng_ignore_err_out(eng_ignore_err_out), .eng_tx_go_out(eng_tx_go_out));
